// >>> hw/ccr_charge_config_regs.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Pre-charge limit is 128 mA plus 128 mA per step of bits 7:4.
// - Termination limit is 128 mA plus 128 mA per step of bits 3:0.
// - Regulation voltage is 3.504 V plus 16 mV per step, capped 4.400 V.
// - Bit 1 picks fast-charge entry: 0 gives 2.8 V, 1 gives 3.0 V.
// - Bit 0 picks recharge margin: 0 gives 100 mV, 1 gives 300 mV.
// - Termination at end current happens only when bit 7 is set.
// - Watchdog period bits 5:4: off, 40 s, 80 s, 160 s.
// - Safety timer on bit 3 limits fast charge to 5/8/12/20 hours.
// - Reset loads 0x11 and 0xB2 into the first two registers.
// - Reset loads 0x9C into timer register; bits 6 and 0 read zero.
// - Boost code bits 7:4, hot select 3:2, thermal select 1:0; reset 0x93.
// - Boost voltage is 4.55 V plus 64 mV per step of the code.
// - Thermal regulation threshold 60, 80, 100 or 120 degrees C.
// - Hot code 11 disables boost thermal cut, fault uses default threshold.
module ccr_charge_config_regs
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // Register port from the serial management engine
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output var  logic [7:0]  reg_rdata,
    // Decoded settings for the analog loops
    output var  logic [11:0] precharge_current_ma,
    output var  logic [11:0] term_current_ma,
    output var  logic [12:0] charge_voltage_mv,
    output var  logic [11:0] fast_charge_entry_mv,
    output var  logic [8:0]  recharge_margin_mv,
    output var  logic        term_enable,
    output var  logic        watchdog_enable,
    output var  logic [7:0]  watchdog_period_s,
    output var  logic        safety_timer_enable,
    output var  logic [4:0]  fast_charge_time_h,
    output var  logic [12:0] boost_out_mv,
    output var  logic        boost_hot_protect_en,
    output var  logic [1:0]  boost_hot_sel,
    output var  logic [1:0]  ntc_fault_hot_sel,
    output var  logic [6:0]  thermal_reg_c
);

    typedef struct packed {
        // Stored registers
        logic [7:0]  pre_term;
        logic [7:0]  chg_volt;
        logic [7:0]  term_tmr;
        logic [7:0]  boost_thm;

        // Registered read data
        logic [7:0]  rdata;

        // Decoded settings, one flop per output
        logic [11:0] pre_ma;
        logic [11:0] term_ma;
        logic [12:0] charge_voltage_code_mv;
        logic [11:0] lowv_mv;
        logic [8:0]  rechg_mv;
        logic        term_en;
        logic        wdog_en;
        logic [7:0]  wdog_s;
        logic        tmr_en;
        logic [4:0]  tmr_h;
        logic [12:0] boost_mv;
        logic        bhot_en;
        logic [1:0]  bhot_sel;
        logic [1:0]  ntc_sel;
        logic [6:0]  thermal_reg_sel_c;
    } ccr_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops so every register leaves reset together
    logic [1:0] rst_sync_r;
    logic       rst_n_int;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n_int = rst_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Code to value tables shared by the decode
    function automatic logic [7:0] wdog_seconds(input logic [1:0] code);
        case (ccr_wdog_t'(code))
            CCR_WDOG_40:  wdog_seconds = CCR_WDOG_S_40;
            CCR_WDOG_80:  wdog_seconds = CCR_WDOG_S_80;
            CCR_WDOG_160: wdog_seconds = CCR_WDOG_S_160;
            default:      wdog_seconds = 8'h00;
        endcase
    endfunction

    // Safety timer lengths
    function automatic logic [4:0] timer_hours(input logic [1:0] code);
        case (code)
            2'h0:    timer_hours = CCR_TMR_H_5;
            2'h1:    timer_hours = CCR_TMR_H_8;
            2'h2:    timer_hours = CCR_TMR_H_12;
            default: timer_hours = CCR_TMR_H_20;
        endcase
    endfunction

    // Thermal regulation thresholds
    function automatic logic [6:0] thermal_reg_sel_celsius(input logic [1:0] code);
        case (code)
            2'h0:    thermal_reg_sel_celsius = CCR_THERMAL_REG_SEL_C_60;
            2'h1:    thermal_reg_sel_celsius = CCR_THERMAL_REG_SEL_C_80;
            2'h2:    thermal_reg_sel_celsius = CCR_THERMAL_REG_SEL_C_100;
            default: thermal_reg_sel_celsius = CCR_THERMAL_REG_SEL_C_120;
        endcase
    endfunction

    // Both current fields share one scale
    function automatic logic [11:0] current_ma(input logic [3:0] code);
        current_ma = CCR_I_OFS_MA + 12'(code) * CCR_I_STEP_MA;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    ccr_state_t st_r;
    ccr_state_t st_nxt;
    logic [12:0] charge_voltage_code_raw;

    always_comb begin
        st_nxt = st_r;
        charge_voltage_code_raw = 13'h0000;

        // A write lands at the edge that samples the strobe
        if (reg_wr) begin
            case (reg_addr)
                CCR_OFS_PRE_TERM:  st_nxt.pre_term = reg_wdata;
                CCR_OFS_CHG_VOLT:  st_nxt.chg_volt = reg_wdata;
                CCR_OFS_TERM_TMR:  st_nxt.term_tmr = reg_wdata & CCR_TERM_TMR_WMASK;
                CCR_OFS_BOOST_THM: st_nxt.boost_thm = reg_wdata;
                default: ;
            endcase
        end

        // Read data is the stored value; unmapped offsets read zero
        case (reg_addr)
            CCR_OFS_PRE_TERM:  st_nxt.rdata = st_r.pre_term;
            CCR_OFS_CHG_VOLT:  st_nxt.rdata = st_r.chg_volt;
            CCR_OFS_TERM_TMR:  st_nxt.rdata = st_r.term_tmr;
            CCR_OFS_BOOST_THM: st_nxt.rdata = st_r.boost_thm;
            default:           st_nxt.rdata = 8'h00;
        endcase

        // Decoded settings follow the stored registers one cycle later
        st_nxt.pre_ma  = current_ma(st_r.pre_term[CCR_PRE_LSB +: 4]);
        st_nxt.term_ma = current_ma(st_r.pre_term[CCR_TERM_LSB +: 4]);

        // Codes above the limit would pass 4.400 V, so they saturate
        charge_voltage_code_raw = CCR_CHARGE_VOLTAGE_CODE_OFS_MV + 13'(st_r.chg_volt[CCR_CHARGE_VOLTAGE_CODE_LSB +: 6]) * CCR_CHARGE_VOLTAGE_CODE_STEP_MV;
        st_nxt.charge_voltage_code_mv = (charge_voltage_code_raw > CCR_CHARGE_VOLTAGE_CODE_MAX_MV) ? CCR_CHARGE_VOLTAGE_CODE_MAX_MV : charge_voltage_code_raw;
        st_nxt.lowv_mv = st_r.chg_volt[CCR_LOWV_BIT] ? CCR_LOWV_HI_MV : CCR_LOWV_LO_MV;
        st_nxt.rechg_mv = st_r.chg_volt[CCR_RECHG_BIT] ? CCR_RECHG_HI_MV : CCR_RECHG_LO_MV;

        // Termination and timers
        st_nxt.term_en = st_r.term_tmr[CCR_ENTERM_BIT];
        st_nxt.wdog_en = (st_r.term_tmr[CCR_WDOG_LSB +: 2] != CCR_WDOG_OFF);
        st_nxt.wdog_s  = wdog_seconds(st_r.term_tmr[CCR_WDOG_LSB +: 2]);
        st_nxt.tmr_en  = st_r.term_tmr[CCR_ENTMR_BIT];
        st_nxt.tmr_h   = timer_hours(st_r.term_tmr[CCR_TMR_LSB +: 2]);

        // Boost and thermal
        st_nxt.boost_mv = CCR_BOOST_OFS_MV
                        + 13'(st_r.boost_thm[CCR_BOOST_LSB +: 4]) * CCR_BOOST_STEP_MV;
        st_nxt.bhot_sel = st_r.boost_thm[CCR_BHOT_LSB +: 2];
        st_nxt.bhot_en  = (st_r.boost_thm[CCR_BHOT_LSB +: 2] != CCR_BHOT_OFF);
        st_nxt.ntc_sel  = st_nxt.bhot_en ? st_r.boost_thm[CCR_BHOT_LSB +: 2]
                                         : CCR_BHOT_DEFAULT;
        st_nxt.thermal_reg_sel_c   = thermal_reg_sel_celsius(st_r.boost_thm[CCR_THERMAL_REG_SEL_LSB +: 2]);
    end

    // Decoded outputs and read data stay zero while reset is held
    always_ff @(posedge clk_sys or negedge rst_n_int) begin
        if (!rst_n_int) begin
            st_r           <= '0;
            st_r.pre_term  <= CCR_RST_PRE_TERM;
            st_r.chg_volt  <= CCR_RST_CHG_VOLT;
            st_r.term_tmr  <= CCR_RST_TERM_TMR;
            st_r.boost_thm <= CCR_RST_BOOST_THM;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port
    assign reg_rdata            = st_r.rdata;

    // Charge settings
    assign precharge_current_ma = st_r.pre_ma;
    assign term_current_ma      = st_r.term_ma;
    assign charge_voltage_mv    = st_r.charge_voltage_code_mv;
    assign fast_charge_entry_mv = st_r.lowv_mv;
    assign recharge_margin_mv   = st_r.rechg_mv;

    // Termination and timer settings
    assign term_enable          = st_r.term_en;
    assign watchdog_enable      = st_r.wdog_en;
    assign watchdog_period_s    = st_r.wdog_s;
    assign safety_timer_enable  = st_r.tmr_en;
    assign fast_charge_time_h   = st_r.tmr_h;

    // Boost and thermal settings
    assign boost_out_mv         = st_r.boost_mv;
    assign boost_hot_protect_en = st_r.bhot_en;
    assign boost_hot_sel        = st_r.bhot_sel;
    assign ntc_fault_hot_sel    = st_r.ntc_sel;
    assign thermal_reg_c        = st_r.thermal_reg_sel_c;

endmodule
`default_nettype wire

// >>> hw/ccr_pkg.sv
package ccr_pkg;

    // Register offsets on the management port
    localparam logic [7:0] CCR_OFS_PRE_TERM  = 8'h03;
    localparam logic [7:0] CCR_OFS_CHG_VOLT  = 8'h04;
    localparam logic [7:0] CCR_OFS_TERM_TMR  = 8'h05;
    localparam logic [7:0] CCR_OFS_BOOST_THM = 8'h06;

    // Reset values
    localparam logic [7:0] CCR_RST_PRE_TERM  = 8'h11;
    localparam logic [7:0] CCR_RST_CHG_VOLT  = 8'hB2;
    localparam logic [7:0] CCR_RST_TERM_TMR  = 8'h9C;
    localparam logic [7:0] CCR_RST_BOOST_THM = 8'h93;

    // Field positions
    localparam int CCR_PRE_LSB    = 4;
    localparam int CCR_TERM_LSB   = 0;
    localparam int CCR_CHARGE_VOLTAGE_CODE_LSB   = 2;
    localparam int CCR_LOWV_BIT   = 1;
    localparam int CCR_RECHG_BIT  = 0;
    localparam int CCR_ENTERM_BIT = 7;
    localparam int CCR_WDOG_LSB   = 4;
    localparam int CCR_ENTMR_BIT  = 3;
    localparam int CCR_TMR_LSB    = 1;
    localparam int CCR_BOOST_LSB  = 4;
    localparam int CCR_BHOT_LSB   = 2;
    localparam int CCR_THERMAL_REG_SEL_LSB   = 0;

    // Writable bits of the termination/timer register; bits 6 and 0 are reserved
    localparam logic [7:0] CCR_TERM_TMR_WMASK = 8'hBE;

    // Analog scaling, in mA, mV, s, hours and degrees C
    localparam logic [11:0] CCR_I_OFS_MA      = 12'h080;
    localparam logic [11:0] CCR_I_STEP_MA     = 12'h080;
    localparam logic [12:0] CCR_CHARGE_VOLTAGE_CODE_OFS_MV   = 13'h0DB0;
    localparam logic [12:0] CCR_CHARGE_VOLTAGE_CODE_STEP_MV  = 13'h0010;
    localparam logic [12:0] CCR_CHARGE_VOLTAGE_CODE_MAX_MV   = 13'h1130;
    localparam logic [11:0] CCR_LOWV_LO_MV    = 12'hAF0;
    localparam logic [11:0] CCR_LOWV_HI_MV    = 12'hBB8;
    localparam logic [8:0]  CCR_RECHG_LO_MV   = 9'h064;
    localparam logic [8:0]  CCR_RECHG_HI_MV   = 9'h12C;
    localparam logic [12:0] CCR_BOOST_OFS_MV  = 13'h11C6;
    localparam logic [12:0] CCR_BOOST_STEP_MV = 13'h0040;

    typedef enum logic [1:0] {
        CCR_WDOG_OFF = 2'h0,
        CCR_WDOG_40  = 2'h1,
        CCR_WDOG_80  = 2'h2,
        CCR_WDOG_160 = 2'h3
    } ccr_wdog_t;

    localparam logic [7:0] CCR_WDOG_S_40  = 8'h28;
    localparam logic [7:0] CCR_WDOG_S_80  = 8'h50;
    localparam logic [7:0] CCR_WDOG_S_160 = 8'hA0;

    localparam logic [4:0] CCR_TMR_H_5  = 5'h05;
    localparam logic [4:0] CCR_TMR_H_8  = 5'h08;
    localparam logic [4:0] CCR_TMR_H_12 = 5'h0C;
    localparam logic [4:0] CCR_TMR_H_20 = 5'h14;

    localparam logic [6:0] CCR_THERMAL_REG_SEL_C_60  = 7'h3C;
    localparam logic [6:0] CCR_THERMAL_REG_SEL_C_80  = 7'h50;
    localparam logic [6:0] CCR_THERMAL_REG_SEL_C_100 = 7'h64;
    localparam logic [6:0] CCR_THERMAL_REG_SEL_C_120 = 7'h78;

    // Boost hot code that turns boost thermal protection off
    localparam logic [1:0] CCR_BHOT_OFF     = 2'h3;
    localparam logic [1:0] CCR_BHOT_DEFAULT = 2'h0;

endpackage

// >>> tb/ccr_charge_config_regs_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_charge_config_regs_asserts
    import ccr_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Decoded settings
    input wire logic [11:0] precharge_current_ma,
    input wire logic [11:0] term_current_ma,
    input wire logic [12:0] charge_voltage_mv,
    input wire logic [11:0] fast_charge_entry_mv,
    input wire logic [8:0]  recharge_margin_mv,
    input wire logic        term_enable,
    input wire logic        watchdog_enable,
    input wire logic [7:0]  watchdog_period_s,
    input wire logic        safety_timer_enable,
    input wire logic [4:0]  fast_charge_time_h,
    input wire logic [12:0] boost_out_mv,
    input wire logic        boost_hot_protect_en,
    input wire logic [1:0]  boost_hot_sel,
    input wire logic [1:0]  ntc_fault_hot_sel,
    input wire logic [6:0]  thermal_reg_c
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // Write data two edges back: decoded outputs lag a write by two edges
    logic [7:0] wd1;
    logic [7:0] wd2;
    always_ff @(posedge clk_sys) begin
        wd1 <= reg_wdata;
        wd2 <= wd1;
    end
    wire logic w3 = reg_wr && reg_addr == CCR_OFS_PRE_TERM;
    wire logic w4 = reg_wr && reg_addr == CCR_OFS_CHG_VOLT;
    wire logic w5 = reg_wr && reg_addr == CCR_OFS_TERM_TMR;
    wire logic w6 = reg_wr && reg_addr == CCR_OFS_BOOST_THM;
    a_pre_current: assert property (w3 |-> ##2 precharge_current_ma == 12'h080 + 12'h080 * wd2[7:4])
        else $error("pre-charge current wrong");
    a_term_current: assert property (w3 |-> ##2 term_current_ma == 12'h080 + 12'h080 * wd2[3:0])
        else $error("termination current wrong");
    a_chg_volt: assert property (w4 |-> ##2 charge_voltage_mv ==
        (wd2[7:2] > 6'h38 ? 13'h1130 : 13'h0DB0 + 13'h0010 * wd2[7:2])) else $error("charge voltage wrong");
    a_entry_margin: assert property (w4 |-> ##2 fast_charge_entry_mv == (wd2[1] ? 12'hBB8 : 12'hAF0)
        && recharge_margin_mv == (wd2[0] ? 9'h12C : 9'h064)) else $error("entry or margin wrong");
    a_tmr_enables: assert property (w5 |-> ##2
        {term_enable, watchdog_enable, safety_timer_enable} == {wd2[7], |wd2[5:4], wd2[3]}) else $error("enables wrong");
    a_wdog_period: assert property (w5 |-> ##2 watchdog_period_s ==
        (wd2[5:4] == 2'h0 ? 8'h00 : 8'h28 << (wd2[5:4] - 2'h1))) else $error("watchdog period wrong");
    a_chg_hours: assert property (w5 |-> ##2 fast_charge_time_h ==
        (wd2[2] ? (wd2[1] ? 5'h14 : 5'h0C) : (wd2[1] ? 5'h08 : 5'h05))) else $error("charge hours wrong");
    a_rsvd_zero: assert property (reg_addr == CCR_OFS_TERM_TMR |=> reg_rdata[6] == 1'b0 && reg_rdata[0] == 1'b0)
        else $error("reserved bits not zero");
    a_boost_mv: assert property (w6 |-> ##2 boost_out_mv == 13'h11C6 + 13'h0040 * wd2[7:4])
        else $error("boost voltage wrong");
    a_thermal_sel: assert property (w6 |-> ##2 thermal_reg_c == 7'h3C + 7'h14 * wd2[1:0])
        else $error("thermal threshold wrong");
    a_boost_hot: assert property (w6 |-> ##2 {boost_hot_sel, boost_hot_protect_en, ntc_fault_hot_sel} ==
        {wd2[3:2], wd2[3:2] != 2'h3, (&wd2[3:2]) ? 2'h0 : wd2[3:2]}) else $error("boost hot select wrong");
    a_rw_readback: assert property ((w3 || w4 || w6) ##1 (!reg_wr && $stable(reg_addr)) |=> reg_rdata == wd2)
        else $error("readback wrong");
    cover property (w5 && reg_wdata[6]);
    cover property (w5 ##1 w6);
    cover property (reg_wr && reg_addr > CCR_OFS_BOOST_THM);
endmodule
bind ccr_charge_config_regs ccr_charge_config_regs_asserts u_chk (.*);
`default_nettype wire

// >>> tb/ccr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ccr_host_model (
    // Clock
    input  wire logic       clk_sys,
    // Register port
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic [7:0] reg_wdata
);
    initial {reg_addr, reg_wr, reg_wdata} = 17'h00000;
    // Strobe is left high so the next write can follow on the very next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rude);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wr = 1'b1;
        reg_wdata = (a == 8'h05 && !rude) ? d & 8'hBE : d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wr = 1'b0;
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// >>> tb/ccr_charge_config_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t %h %h", $time, g, e); end end
module ccr_charge_config_regs_tb;
    logic            clk_sys, reset_n, rd_flag;
    logic [7:0]      a, q[$], mir[8], exp_rd;
    int              n_errors, n_tests, cyc;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
    wire logic       reg_wr;
    wire logic [98:0] dec;
    ccr_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    ccr_charge_config_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .precharge_current_ma(dec[98:87]),
        .term_current_ma(dec[86:75]), .charge_voltage_mv(dec[74:62]), .fast_charge_entry_mv(dec[61:50]),
        .recharge_margin_mv(dec[49:41]), .term_enable(dec[40]), .watchdog_enable(dec[39]),
        .watchdog_period_s(dec[38:31]), .safety_timer_enable(dec[30]), .fast_charge_time_h(dec[29:25]),
        .boost_out_mv(dec[24:12]), .boost_hot_protect_en(dec[11]), .boost_hot_sel(dec[10:9]),
        .ntc_fault_hot_sel(dec[8:7]), .thermal_reg_c(dec[6:0]));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    // Read data is registered, so it is checked half a cycle after the edge that loads it
    always @(negedge clk_sys) if (rd_flag === 1'b1) begin
        rd_flag = 1'b0;
        // Pop once: the macro names its expected value twice
        exp_rd = q.pop_front();
        `CHK(reg_rdata, exp_rd)
    end
    task automatic chk(input logic [7:0] ad);
        q.push_back((ad >= 8'h03 && ad <= 8'h06) ? mir[ad[2:0]] : 8'h00);
        host.rd(ad);
        #1 rd_flag = 1'b1;
    endtask
    task automatic put(input logic [7:0] ad, input logic [7:0] d, input bit rude);
        host.wr(ad, d, rude);
        if (ad >= 8'h03 && ad <= 8'h06) mir[ad[2:0]] = (ad == 8'h05) ? d & 8'hBE : d;
    endtask
    task automatic do_reset();
        // Let a pending read check finish before reset clears the read data
        @(posedge clk_sys);
        #1 reset_n = 1'b0;
        mir = '{8'h00, 8'h00, 8'h00, 8'h11, 8'hB2, 8'h9C, 8'h93, 8'h00};
        repeat (10) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        `CHK(dec, {12'h100, 12'h100, 13'h1070, 12'hBB8, 9'h064, 1'h1, 1'h1, 8'h28, 1'h1, 5'h0C, 13'h1406, 1'h1, 2'h0, 2'h0, 7'h78})
        for (int i = 2; i < 8; i++) chk(8'(i));
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rd_flag, reset_n, n_errors, n_tests, cyc} = '0;
        void'($urandom(32'h8125160d));
        do_reset();
        put(8'h05, 8'hFF, 1'b1);
        chk(8'h05);
        // Every watchdog, timer, hot and thermal code, plus a saturating voltage code
        for (int i = 0; i < 4; i++) begin
            put(8'h05, 8'(($urandom() & 32'hC9) | (i << 4) | (i << 1)), 1'b0);
            put(8'h06, 8'(($urandom() & 32'hF0) | (i << 2) | i), 1'b0);
            put(8'h04, (i == 3) ? 8'hFF : 8'($urandom()), 1'b0);
            put(8'h03, 8'($urandom()), 1'b0);
            chk(8'h05);
            chk(8'h06);
        end
        repeat (40) begin
            a = 8'($urandom_range(7, 2));
            put(a, 8'($urandom()), 1'b0);
            chk(a);
        end
        do_reset();
        @(posedge clk_sys);
        `CHK(q.size(), 0)
        wrap_up();
    end
endmodule
`default_nettype wire
